// ===== verilog/adcwf_pkg.sv
// Purpose: shared constants for the adc channel word formatter
// Assumes: apb register map, 32-bit words, byte addresses
// Notes:   register offsets, word field positions and the enable reset value live here
package adcwf_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADCWF_CTRL_ADDR  = 8'h00; // control, rw
    localparam logic [7:0]  ADCWF_WORD_ADDR  = 8'h04; // {upper, lower} word, ro
    localparam logic [7:0]  ADCWF_STAT_ADDR  = 8'h08; // scan state, ro

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          ADCWF_CTL_WIDE   = 0;     // 1: two-word layout
    localparam int          ADCWF_CTL_FMT_LO = 1;     // format, bits 2:1
    localparam int          ADCWF_CTL_BIP    = 3;     // bipolar range
    localparam int          ADCWF_CTL_DET    = 4;     // 4-20 ma with detection
    localparam int          ADCWF_CTL_EN_LO  = 8;     // channel enables, 11:8
    localparam logic [3:0]  ADCWF_EN_RST     = 4'hf;  // all channels on

    // ------------------------------------------------------------
    // word field positions
    // ------------------------------------------------------------
    localparam int          ADCWF_SIGN_BIT   = 15;    // single-word sign
    localparam int          ADCWF_BRK_BIT    = 14;    // single-word broken
    localparam int          ADCWF_CHN_LO     = 12;    // single-word channel code
    localparam int          ADCWF_HSIGN_LO   = 4;     // upper word sign flags
    localparam int          ADCWF_HBRK_LO    = 8;     // upper word broken flags

    // data formats of the lower word in the two-word layout
    typedef enum logic [1:0] {
        ADCWF_FMT_MAG,       // 12-bit magnitude plus sign
        ADCWF_FMT_TC13,      // 13-bit two's complement
        ADCWF_FMT_TC12,      // 12-bit two's complement
        ADCWF_FMT_BCD        // magnitude as four bcd digits
    } adcwf_fmt_t;

endpackage

// ===== verilog/adcwf_top.sv
// Purpose: turns four converter results into cpu discrete input words
// Assumes: scan_i is a one-cycle pulse from logic on clk_i
// Notes:   converter inputs are asynchronous and pass two flip-flops
//
// Function
// R01: single word: magnitude in bits 0-11
// R02: single word: bit 15 flags negative input
// R03: unipolar range keeps sign at zero
// R04: single word: bit 14 flags low current
// R05: upper word bits 0-3 one-hot channel
// R06: indicator refreshed each scan, wraps around
// R07: four selectable lower word formats
// R08: magnitude formats use bits 0-11
// R09: two's complement spans all 16 bits
// R10: bcd format: four digits, 0000 to 9999 (the code's top is 4095)
// R11: upper word bits 4-7 channel signs
// R12: upper word bits 8-11 broken flags
// R13: single word offers only magnitude plus sign
// R14: value scaled linearly over 0 to 4095
// R15: bipolar 13-bit: 4095 to 61440 (the code's negative end is 61441)
// R16: negative code is invert plus one
// R17: 12-bit unipolar, 13-bit bipolar resolution
// R18: two-word layout fills 32 input points
// R19: single word bits 12-13 channel code
// R20: one channel per scan, cyclic
// R21: disabled channels skipped in rotation
// R22: all fields change together per scan
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
module adcwf_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // converter results, asynchronous
    input  wire logic [47:0] conv_mag_i,
    input  wire logic [3:0]  conv_neg_i,
    input  wire logic [3:0]  conv_low_i,
    // cpu scan side
    input  wire logic        scan_i,
    output logic      [15:0] word_lo_o,
    output logic      [15:0] word_hi_o
);
    import adcwf_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        wide_r;          // two-word layout
    adcwf_fmt_t  fmt_r;           // lower word format
    logic        bip_r;           // bipolar range
    logic        det_r;           // broken detection range
    logic [3:0]  en_r;            // channel enables
    logic [1:0]  chan_r;          // presented channel, 0 = ch 1
    logic [1:0]  chan_nxt;        // next enabled channel
    logic [3:0]  ind_r;           // one-hot copy of chan_r
    logic [15:0] lo_r;            // lower / single word
    logic [15:0] hi_r;            // upper word
    logic [15:0] lo_nxt;          // lower word to latch
    logic [15:0] hi_nxt;          // upper word to latch
    logic [15:0] scans_r;         // scans seen, for status
    logic [47:0] mag_s1_r;        // synchroniser stage 1
    logic [47:0] mag_r;           // synchronised magnitudes
    logic [7:0]  flg_s1_r;        // {low, neg} stage 1
    logic [7:0]  flg_r;           // {low, neg} synchronised
    logic [11:0] mag_sel;         // magnitude of next channel (chan_nxt)
    logic [3:0]  neg_ch;          // per-channel sign, range gated
    logic [3:0]  brk_ch;          // per-channel broken, range gated
    logic [15:0] tc13;            // 13-bit two's complement code
    logic [15:0] tc12;            // 12-bit two's complement code
    logic        wr_ctrl;         // apb write to control

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // the result words are not coherent across the crossing; the
    // converter is assumed to hold each result far longer than two
    // clocks, so a torn value lasts at most one cycle before a scan
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mag_s1_r <= '0;
            mag_r    <= '0;
            flg_s1_r <= '0;
            flg_r    <= '0;
        end else begin
            mag_s1_r <= conv_mag_i;
            mag_r    <= mag_s1_r;
            flg_s1_r <= {conv_low_i, conv_neg_i};
            flg_r    <= flg_s1_r;
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // writes to the read-only words are dropped, with no error
    assign pready_o = 1'b1;                 // zero wait states
    assign wr_ctrl  = psel_i && penable_i && pwrite_i
                      && (paddr_i == ADCWF_CTRL_ADDR);

    // control register, the only writable state
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wide_r <= 1'b0;
            fmt_r  <= ADCWF_FMT_MAG;
            bip_r  <= 1'b0;
            det_r  <= 1'b0;
            en_r   <= ADCWF_EN_RST;
        end else if (wr_ctrl) begin
            wide_r <= pwdata_i[ADCWF_CTL_WIDE];
            fmt_r  <= adcwf_fmt_t'(pwdata_i[ADCWF_CTL_FMT_LO +: 2]);
            bip_r  <= pwdata_i[ADCWF_CTL_BIP];
            det_r  <= pwdata_i[ADCWF_CTL_DET];
            en_r   <= pwdata_i[ADCWF_CTL_EN_LO +: 4];
        end
    end

    // read mux; unmapped addresses read zero with an error
    always_comb begin
        prdata_o  = 32'h0;
        pslverr_o = 1'b0;
        if (paddr_i == ADCWF_CTRL_ADDR) begin
            prdata_o[ADCWF_CTL_WIDE]          = wide_r;
            prdata_o[ADCWF_CTL_FMT_LO +: 2]   = fmt_r;
            prdata_o[ADCWF_CTL_BIP]           = bip_r;
            prdata_o[ADCWF_CTL_DET]           = det_r;
            prdata_o[ADCWF_CTL_EN_LO +: 4]    = en_r;
        end else if (paddr_i == ADCWF_WORD_ADDR) begin
            prdata_o = {hi_r, lo_r};
        end else if (paddr_i == ADCWF_STAT_ADDR) begin
            prdata_o = {scans_r, 12'h0, ind_r};
        end else begin
            pslverr_o = psel_i && penable_i;
        end
    end

    // ------------------------------------------------------------
    // channel rotation
    // ------------------------------------------------------------
    // first enabled channel after the current one, wrapping;
    // with no channel enabled the rotation simply stands still
    always_comb begin
        logic [1:0] c;
        c        = chan_r;
        chan_nxt = chan_r;
        for (int k = 1; k <= 4; k++) begin
            c = chan_r + 2'(k);
            if (en_r[c] && chan_nxt == chan_r && k < 4) begin
                chan_nxt = c;                          // R21
            end
        end
        if (chan_nxt == chan_r && !en_r[chan_r] && en_r != 4'h0) begin
            chan_nxt = chan_r;
        end
    end

    // one channel per scan, wraps after the last enabled channel
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chan_r  <= 2'h0;
            ind_r   <= 4'h1;
            scans_r <= 16'h0;
        end else if (scan_i) begin
            chan_r  <= chan_nxt;                       // R20
            ind_r   <= 4'h1 << chan_nxt;               // R06
            scans_r <= scans_r + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // per-channel flags
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            assign neg_ch[g] = bip_r && flg_r[g];      // R03
            assign brk_ch[g] = det_r && flg_r[4 + g];  // R12
        end
    endgenerate

    // converter already scales each range over 0..4095
    assign mag_sel = mag_r[chan_nxt * 12 +: 12];       // R14

    // invert every bit then add one over the whole word; positive
    // full scale reads 4095, while a 12-bit magnitude stops the
    // negative end at 61441, one count short of the 13-bit floor
    assign tc13 = neg_ch[chan_nxt] ? (~{4'h0, mag_sel}) + 16'h1  // R15
                                   : {4'h0, mag_sel};  // R16
    // older 12-bit code drops the lowest magnitude bit
    assign tc12 = neg_ch[chan_nxt] ? (~{5'h0, mag_sel[11:1]}) + 16'h1
                                   : {5'h0, mag_sel[11:1]};

    // binary to four bcd digits, shift and add three
    function automatic logic [15:0] to_bcd(input logic [11:0] v);
        logic [15:0] d;
        d = 16'h0;
        for (int i = 11; i >= 0; i--) begin
            for (int n = 0; n < 4; n++) begin
                if (d[n*4 +: 4] > 4'h4) begin
                    d[n*4 +: 4] = d[n*4 +: 4] + 4'h3;
                end
            end
            d = {d[14:0], v[i]};
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // word assembly
    // ------------------------------------------------------------
    always_comb begin
        lo_nxt = 16'h0;
        hi_nxt = 16'h0;
        if (!wide_r) begin
            // single word: magnitude plus sign only      // R13
            lo_nxt[11:0]             = mag_sel;          // R01
            lo_nxt[ADCWF_CHN_LO +: 2] = chan_nxt;        // R19
            lo_nxt[ADCWF_BRK_BIT]    = brk_ch[chan_nxt]; // R04
            lo_nxt[ADCWF_SIGN_BIT]   = neg_ch[chan_nxt]; // R02
        end else begin
            // two words, 32 input points                 // R18
            hi_nxt[3:0]                 = 4'h1 << chan_nxt;  // R05
            hi_nxt[ADCWF_HSIGN_LO +: 4] = neg_ch;            // R11
            hi_nxt[ADCWF_HBRK_LO +: 4]  = brk_ch;            // R12
            case (fmt_r)                                     // R07
                ADCWF_FMT_MAG:  lo_nxt = {4'h0, mag_sel};    // R08
                ADCWF_FMT_TC13: lo_nxt = tc13;               // R09
                ADCWF_FMT_TC12: lo_nxt = tc12;               // R09
                default:        lo_nxt = to_bcd(mag_sel);    // R10
            endcase
        end
    end

    // both words latch in one edge so no read mixes channels
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lo_r <= 16'h0;
            hi_r <= 16'h0;
        end else if (scan_i) begin
            lo_r <= lo_nxt;                              // R22
            hi_r <= hi_nxt;                              // R22
        end
    end

    assign word_lo_o = lo_r;
    assign word_hi_o = hi_r;
    // sign plus 12 magnitude bits gives 13-bit bipolar span  // R17

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // all checks sample on clk_i and sleep through reset
    a_ind_onehot: assert property (                   // R05
        @(posedge clk_i) disable iff (!reset_n_i)
        $onehot(ind_r))
        else $error("channel indicator not one-hot");

    a_unipol_sign: assert property (                  // R03
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && !bip_r && !wide_r) |=> !lo_r[ADCWF_SIGN_BIT])
        else $error("sign set on unipolar range");

    a_full_rotate: assert property (                  // R06
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && en_r == 4'hf) |=> chan_r == $past(chan_r) + 2'h1)
        else $error("rotation did not step by one");

    a_skip_off: assert property (                     // R21
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && en_r != 4'h0 && !wr_ctrl) |=> en_r[chan_r])
        else $error("disabled channel presented");

    a_words_hold: assert property (                   // R22
        @(posedge clk_i) disable iff (!reset_n_i)
        !scan_i |=> $stable(lo_r) && $stable(hi_r))
        else $error("word changed between scans");

    a_chan_code: assert property (                    // R19
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && !wide_r) |=> lo_r[13:12] == chan_r)
        else $error("channel code mismatch");

    a_brk_gate: assert property (                     // R12
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && !det_r) |=> hi_r[11:8] == 4'h0)
        else $error("broken flag outside current range");

    a_tc_sum: assert property (                       // R16
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && fmt_r == ADCWF_FMT_TC13
         && neg_ch[chan_nxt])
        |=> lo_r + {4'h0, $past(mag_sel)} == 16'h0)
        else $error("negative code not two's complement");

    a_bcd_digits: assert property (                   // R10
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && fmt_r == ADCWF_FMT_BCD)
        |=> lo_r[3:0] <= 4'h9 && lo_r[7:4] <= 4'h9
            && lo_r[11:8] <= 4'h9 && lo_r[15:12] <= 4'h9)
        else $error("bcd digit above nine");

    // single-word layout
    a_mag_field: assert property (                    // R01
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && !wide_r) |=> lo_r[11:0] == $past(mag_sel))
        else $error("single word magnitude wrong");

    a_brk_word: assert property (                     // R04
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && !wide_r && !det_r) |=> !lo_r[ADCWF_BRK_BIT])
        else $error("broken bit set without detection");

    a_hi_single: assert property (                    // R13
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && !wide_r) |=> hi_r == 16'h0)
        else $error("upper word used in single layout");

    // two-word layout
    a_ind_match: assert property (                    // R05
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r) |=> hi_r[3:0] == ind_r)
        else $error("upper word indicator mismatch");

    a_sign_quiet: assert property (                   // R11
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && !bip_r) |=> hi_r[ADCWF_HSIGN_LO +: 4] == 4'h0)
        else $error("sign flags set on unipolar range");

    a_mag_lower: assert property (                    // R08
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && fmt_r == ADCWF_FMT_MAG)
        |=> lo_r == {4'h0, $past(mag_sel)})
        else $error("lower word magnitude wrong");

    a_tc_pos: assert property (                       // R15
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && fmt_r == ADCWF_FMT_TC13 && !neg_ch[chan_nxt])
        |=> lo_r == {4'h0, $past(mag_sel)})
        else $error("positive two's complement code wrong");

    a_tc_sign: assert property (                      // R09
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && fmt_r == ADCWF_FMT_TC13 && neg_ch[chan_nxt]
         && mag_sel != 12'h0) |=> lo_r[15])
        else $error("negative code below the top half");

    a_tc12_sum: assert property (                     // R16
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && fmt_r == ADCWF_FMT_TC12 && neg_ch[chan_nxt])
        |=> lo_r + ({4'h0, $past(mag_sel)} >> 1) == 16'h0)
        else $error("12-bit negative code wrong");

    a_bcd_top: assert property (                      // R10
        @(posedge clk_i) disable iff (!reset_n_i)
        (scan_i && wide_r && fmt_r == ADCWF_FMT_BCD) |=> lo_r[15:12] <= 4'h4)
        else $error("bcd thousands digit out of range");

    // rotation and status
    a_ind_follow: assert property (                   // R06
        @(posedge clk_i) disable iff (!reset_n_i)
        ind_r == (4'h1 << chan_r))
        else $error("indicator does not match channel");

    a_chan_hold: assert property (                    // R20
        @(posedge clk_i) disable iff (!reset_n_i)
        !scan_i |=> $stable(chan_r))
        else $error("channel moved between scans");

    a_scan_count: assert property (                   // R20
        @(posedge clk_i) disable iff (!reset_n_i)
        scan_i |=> scans_r == $past(scans_r) + 16'h1)
        else $error("scan count did not step");

endmodule

// ===== tb/adcwf_cpu_model.sv
// Purpose: cpu side of the scan interface, pulses scan and reads both words
// Assumes: words are registered and settle one edge after the scan pulse
// Notes:   the bench calls do_scan by hierarchical reference
`timescale 1ns/1ns
module adcwf_cpu_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // scan side
    input  wire logic [15:0] word_lo_i,
    input  wire logic [15:0] word_hi_i,
    output logic             scan_o
);
    // ------------------------------------------------------------
    // scan pulse and capture
    // ------------------------------------------------------------
    initial scan_o = 1'b0; // idle until the bench asks for a scan

    // one-cycle pulse, then both words taken at one edge so no mixing
    task automatic do_scan(output logic [15:0] lo, output logic [15:0] hi);
        wait (reset_n_i === 1'b1); // no scan while the block is held in reset
        @(posedge clk_i);
        scan_o <= 1'b1;
        @(posedge clk_i);
        scan_o <= 1'b0;
        @(posedge clk_i);
        lo = word_lo_i; // lower data word
        hi = word_hi_i; // upper flag word
    endtask
endmodule

// ===== tb/adcwf_top_test.sv
// Purpose: self-checking bench for the adc channel word formatter
// Assumes: zero wait apb slave, scans driven by the cpu model
// Notes:   expected words are worked out here from channel state
`timescale 1ns/1ns
module adcwf_top_test;
    import adcwf_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i; // bus and clock
    logic [7:0]  paddr_i;                 // byte address
    logic [31:0] pwdata_i, prdata_o;      // data both ways
    logic        pready_o, pslverr_o;     // answer
    logic [47:0] conv_mag_i;              // four magnitudes
    logic [3:0]  conv_neg_i, conv_low_i;  // per-channel flags
    logic        scan_i;                  // from cpu model
    logic [15:0] word_lo_o, word_hi_o;    // words to cpu
    int          errors, n_checks, cycles, cur;
    logic [31:0] q;
    logic        err;
    logic [15:0] lo, hi;
    adcwf_top adcwf_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .conv_mag_i(conv_mag_i), .conv_neg_i(conv_neg_i), .conv_low_i(conv_low_i),
        .scan_i(scan_i), .word_lo_o(word_lo_o), .word_hi_o(word_hi_o));
    adcwf_cpu_model adcwf_cpu_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .word_lo_i(word_lo_o), .word_hi_i(word_hi_o), .scan_o(scan_i));
    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // a hang is cut short well past the hundred or so cycles needed
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // next enabled channel after the current one, current if none
    function automatic int next_ch(input int c, input logic [3:0] en);
        for (int i = 1; i <= 4; i++) if (en[(c + i) % 4]) return (c + i) % 4;
        return c;
    endfunction
    // lower word by format from magnitude and sign
    function automatic logic [15:0] exp_lo(input int f, input logic [11:0] m, input logic n);
        logic [15:0] v;
        v = (f == 2) ? {5'h0, m[11:1]} : {4'h0, m};
        if (f == 3) v = {4'((m / 1000) % 10), 4'((m / 100) % 10), 4'((m / 10) % 10), 4'(m % 10)};
        else if (f != 0 && n) v = ~v + 16'h0001;
        return v;
    endfunction
    task automatic wrap_up();
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        n_checks = 0;
        cycles = 0;
        cur = 0;
        reset_n_i = 1'b0;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        conv_mag_i = {12'd1, 12'd4095, 12'd2048, 12'd6}; // ch4..ch1
        conv_neg_i = 4'b0011;
        conv_low_i = 4'b1010;
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // reset state and refusal of an unmapped place
        apb(1'b0, ADCWF_CTRL_ADDR, 32'h0);
        check(q, {20'h0, ADCWF_EN_RST, 8'h00});
        apb(1'b0, ADCWF_STAT_ADDR, 32'h0);
        check(q, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        check({31'h0, err}, 32'h1);
        check(q, 32'h0);
        apb(1'b1, ADCWF_WORD_ADDR, 32'hffff_ffff); // read-only, write ignored
        apb(1'b0, ADCWF_WORD_ADDR, 32'h0);
        check(q, 32'h0);
        // single word, bipolar with detection, five scans across the wrap
        apb(1'b1, ADCWF_CTRL_ADDR, 32'h0000_0f18);
        for (int s = 0; s < 5; s++) begin
            adcwf_cpu_model_inst.do_scan(lo, hi);
            cur = next_ch(cur, 4'hf);
            check(lo, {conv_neg_i[cur], conv_low_i[cur], 2'(cur), conv_mag_i[cur*12 +: 12]});
            check(hi, 16'h0);
        end
        apb(1'b0, ADCWF_WORD_ADDR, 32'h0);
        check(q, {16'h0, lo});
        // unipolar, detection off: sign and broken held low on ch4 (low) and ch1 (negative)
        apb(1'b1, ADCWF_CTRL_ADDR, 32'h0000_0f00);
        for (int s = 0; s < 3; s++) begin
            adcwf_cpu_model_inst.do_scan(lo, hi);
            cur = next_ch(cur, 4'hf);
            check(lo, {2'b00, 2'(cur), conv_mag_i[cur*12 +: 12]});
        end
        // two-word layout, every format, channels 1 and 3 only
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, ADCWF_CTRL_ADDR, 32'h0000_0519 | 32'(f << ADCWF_CTL_FMT_LO));
            for (int s = 0; s < 2; s++) begin
                adcwf_cpu_model_inst.do_scan(lo, hi);
                cur = next_ch(cur, 4'b0101);
                check(hi, {4'h0, conv_low_i, conv_neg_i, 4'(1 << cur)});
                check(lo, exp_lo(f, conv_mag_i[cur*12 +: 12], conv_neg_i[cur]));
            end
            apb(1'b0, ADCWF_WORD_ADDR, 32'h0);
            check(q, {hi, lo});
        end
        // detection and bipolar off: upper flags quiet, indicator kept
        apb(1'b1, ADCWF_CTRL_ADDR, 32'h0000_0f01);
        adcwf_cpu_model_inst.do_scan(lo, hi);
        cur = next_ch(cur, 4'hf);
        check(hi, {12'h0, 4'(1 << cur)});
        check(lo, {4'h0, conv_mag_i[cur*12 +: 12]});
        // seventeen scans so far, channel 2 presented last
        apb(1'b0, ADCWF_STAT_ADDR, 32'h0);
        check(q, {16'h11, 12'h0, 4'(1 << cur)});
        wrap_up();
    end
endmodule
